// ---- tsc_pkg.sv ----
package tsc_pkg;

  // controller array shape
  localparam int NUM_CTL = 4;
  localparam int NUM_OUT = 8;

  // time base: one tick paces every delay and every minimum gap
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;

  // register window: eight words per controller, byte stride 0x20
  localparam logic [31:0] MAP_LIMIT = 32'h00000080;
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_OUTCFG = 3'h1;
  localparam logic [2:0] REG_GAP = 3'h2;
  localparam logic [2:0] REG_DLYLO = 3'h3;
  localparam logic [2:0] REG_DLYHI = 3'h4;
  localparam logic [2:0] REG_VALLO = 3'h5;
  localparam logic [2:0] REG_VALHI = 3'h6;
  localparam logic [2:0] REG_STAT = 3'h7;
  localparam int NUM_CFG = 7;
  localparam logic [31:0] REG_RST = 32'h00000000;

  // control word fields
  localparam int CTRL_BIN_EN = 0;
  localparam int CTRL_REACT1_LSB = 4;
  localparam int CTRL_REACT0_LSB = 8;
  localparam int CTRL_SCN_EN = 12;
  localparam int CTRL_SCN_MODE_LSB = 16;
  localparam int CTRL_SCN_SAVE = 20;
  localparam int CTRL_SCN_NUM_LSB = 24;
  localparam int OUTCFG_EN_LSB = 0;
  localparam int OUTCFG_TYPE_LSB = 8;
  localparam int GAP_LSB = 0;

  // scene byte layout: save flag on top, scene number below
  localparam int SCENE_SAVE_BIT = 7;
  localparam int SCENE_NUM_W = 6;

  // bus constants
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [2:0] {
    RC_DISABLED, RC_START, RC_RETRIG, RC_START_ONCE, RC_SAVE, RC_STOP, RC_OFF, RC_OFF_ONCE
  } tsc_react_t;

  typedef enum logic [1:0] {SC_START, SC_RETRIG, SC_START_STOP, SC_START_ONCE} tsc_scene_t;

  typedef enum logic [1:0] {MD_IDLE, MD_RUN, MD_OFF, MD_SAVE} tsc_mode_t;

endpackage

// ---- tsc_ticker.sv ----
module tsc_ticker #(
  parameter int TICK_CYCLES = tsc_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  output logic tick
);

  localparam int CW = $clog2(TICK_CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } tsc_tick_state_t;

  tsc_tick_state_t st_q;
  tsc_tick_state_t st_d;

  // free running divider, one enable pulse per period
  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (st_q.cnt == CW'(TICK_CYCLES - 1)) begin
      st_d.cnt = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + CW'(1);
    end
    if (!reset_n) begin
      st_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    st_q <= st_d;
  end

  assign tick = st_q.tick;

endmodule

// ---- tsc_top.sv ----
// Behaviour
// - four identical controllers, eight outputs each
// - outputs sent together or with own delays
// - binary object, separate reactions for one/zero
// - disabled reaction ignores the received value
// - start from A, ignored while running
// - retrigger restarts from A unless an all-off or save run is busy
// - start once, blocked until all-off runs
// - save reads outputs, responses replace values
// - stop halts the running sequence
// - all-off sends off or zero on every active output
// - all-off skips delays, keeps minimum gap
// - all-off always completes, never interrupted
// - all-off once, blocked until a start
// - scene object reacts only on matching number
// - scene start, ignored until run through
// - scene retrigger restarts from A
// - scene start/stop alternates start and stop
// - scene start once until all-off
// - save-scene command reads and overwrites values
// - minimum gap always kept, beats delays
// - delay from start or previous send
// - output is switch bit or byte value
//
// Implementation choices: register access over AHB-Lite and the placing of the registers.
module tsc_top #(
  parameter int TICK_CYCLES = tsc_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic binValid,
  input wire logic [1:0] binCtl,
  input wire logic binValue,
  input wire logic scnValid,
  input wire logic [1:0] scnCtl,
  input wire logic [7:0] scnByte,
  input wire logic rspValid,
  input wire logic [1:0] rspCtl,
  input wire logic [2:0] rspOut,
  input wire logic [7:0] rspData,
  output logic txValid,
  output logic [1:0] txCtl,
  output logic [2:0] txOut,
  output logic [7:0] txData,
  output logic txRead,
  output logic txSwitch
);

  localparam int NC = tsc_pkg::NUM_CTL;

  typedef struct packed {
    logic hreadyOut;
    logic hresp;
    logic [31:0] hrdata;
    logic busPend;
    logic busWr;
    logic busWord;
    logic busMap;
    logic [1:0] busCtl;
    logic [2:0] busReg;
    logic [NC-1:0][tsc_pkg::NUM_CFG-1:0][31:0] cfg;
    tsc_pkg::tsc_mode_t [NC-1:0] mode;
    logic [NC-1:0][2:0] idx;
    logic [NC-1:0][7:0] dly;
    logic [NC-1:0][7:0] gap;
    logic [NC-1:0] startBlk;
    logic [NC-1:0] offBlk;
    logic txValid;
    logic txRead;
    logic txSwitch;
    logic txOff;
    logic [1:0] txCtl;
    logic [2:0] txOut;
    logic [7:0] txData;
  } tsc_state_t;

  tsc_state_t st_q;
  tsc_state_t st_d;
  logic tick;
  tsc_pkg::tsc_react_t [NC-1:0] rEff;
  logic [NC-1:0] hit;

  // byte i of a two-word table (delays or values, A in the low byte)
  function automatic logic [7:0] pickByte(input logic [31:0] lo, input logic [31:0] hi,
                                         input logic [2:0] i);
    logic [63:0] w;
    w = {hi, lo};
    return w[i*8 +: 8];
  endfunction

  tsc_ticker #(.TICK_CYCLES(TICK_CYCLES)) uTicker (
    .clk(clk),
    .reset_n(reset_n),
    .tick(tick)
  );

  // bus slave, save responses and the four sequencers
  always_comb begin
    logic [31:0] ctl;
    logic [31:0] ocfg;
    logic startReq;
    logic stopReq;
    logic offReq;
    logic saveReq;
    logic once;
    logic busy;
    logic act;
    logic advance;
    logic taken;
    logic [2:0] nIdx;
    logic [7:0] v;
    ctl = '0;
    ocfg = '0;
    startReq = 1'b0;
    stopReq = 1'b0;
    offReq = 1'b0;
    saveReq = 1'b0;
    once = 1'b0;
    busy = 1'b0;
    act = 1'b0;
    advance = 1'b0;
    taken = 1'b0;
    nIdx = '0;
    v = '0;
    st_d = st_q;
    st_d.hresp = tsc_pkg::HRESP_OKAY;
    st_d.txValid = 1'b0;
    st_d.txRead = 1'b0;
    st_d.txOff = 1'b0;

    // one wait state per transfer, so a read never races a write
    if (st_q.busPend) begin
      st_d.busPend = 1'b0;
      st_d.hreadyOut = 1'b1;
      if (!st_q.busWr) begin
        st_d.hrdata = '0;
        if (st_q.busMap && st_q.busReg == tsc_pkg::REG_STAT) begin
          st_d.hrdata = {25'h0, st_q.offBlk[st_q.busCtl], st_q.startBlk[st_q.busCtl],
                         st_q.idx[st_q.busCtl], st_q.mode[st_q.busCtl]};
        end else if (st_q.busMap) begin
          st_d.hrdata = st_q.cfg[st_q.busCtl][st_q.busReg];
        end
      end else if (st_q.busMap && st_q.busWord && st_q.busReg != tsc_pkg::REG_STAT) begin
        st_d.cfg[st_q.busCtl][st_q.busReg] = hwdata;
      end
    end else if (hsel && hready && htrans[1]) begin
      st_d.busPend = 1'b1;
      st_d.hreadyOut = 1'b0;
      st_d.busWr = hwrite;
      st_d.busWord = (hsize == tsc_pkg::HSIZE_WORD);
      st_d.busMap = (haddr < tsc_pkg::MAP_LIMIT);
      st_d.busCtl = haddr[6:5];
      st_d.busReg = haddr[4:2];
    end

    // read response overwrites the stored output value, kept until a later bus write, response or reset
    if (rspValid) begin
      st_d.cfg[rspCtl][rspOut[2] ? tsc_pkg::REG_VALHI : tsc_pkg::REG_VALLO][rspOut[1:0]*8 +: 8] =
        rspData;
    end

    // lowest controller index wins the shared telegram port
    for (int c = 0; c < NC; c++) begin
      ctl = st_q.cfg[c][tsc_pkg::REG_CTRL];
      ocfg = st_q.cfg[c][tsc_pkg::REG_OUTCFG];
      startReq = 1'b0;
      stopReq = 1'b0;
      offReq = 1'b0;
      saveReq = 1'b0;
      once = 1'b0;
      hit[c] = 1'b0;
      rEff[c] = tsc_pkg::RC_DISABLED;

      // binary object wins over a scene aimed at the same controller
      if (binValid && binCtl == 2'(c) && ctl[tsc_pkg::CTRL_BIN_EN]) begin
        hit[c] = 1'b1;
        rEff[c] = tsc_pkg::tsc_react_t'(binValue ? ctl[tsc_pkg::CTRL_REACT1_LSB +: 3]
                                                 : ctl[tsc_pkg::CTRL_REACT0_LSB +: 3]);
      end else if (scnValid && scnCtl == 2'(c) && ctl[tsc_pkg::CTRL_SCN_EN] &&
                   scnByte[tsc_pkg::SCENE_NUM_W-1:0] ==
                   ctl[tsc_pkg::CTRL_SCN_NUM_LSB +: tsc_pkg::SCENE_NUM_W]) begin
        hit[c] = 1'b1;
        if (scnByte[tsc_pkg::SCENE_SAVE_BIT]) begin
          rEff[c] = ctl[tsc_pkg::CTRL_SCN_SAVE] ? tsc_pkg::RC_SAVE : tsc_pkg::RC_DISABLED;
        end else begin
          case (tsc_pkg::tsc_scene_t'(ctl[tsc_pkg::CTRL_SCN_MODE_LSB +: 2]))
            tsc_pkg::SC_START: rEff[c] = tsc_pkg::RC_START;
            tsc_pkg::SC_RETRIG: rEff[c] = tsc_pkg::RC_RETRIG;
            tsc_pkg::SC_START_STOP: begin
              rEff[c] = (st_q.mode[c] == tsc_pkg::MD_RUN) ? tsc_pkg::RC_STOP
                                                          : tsc_pkg::RC_RETRIG;
            end
            tsc_pkg::SC_START_ONCE: rEff[c] = tsc_pkg::RC_START_ONCE;
            default: rEff[c] = tsc_pkg::RC_DISABLED;
          endcase
        end
      end

      // reaction decode; disabled falls through with nothing requested
      case (rEff[c])
        tsc_pkg::RC_START: startReq = (st_q.mode[c] != tsc_pkg::MD_RUN);
        tsc_pkg::RC_RETRIG: startReq = 1'b1;
        tsc_pkg::RC_START_ONCE: begin
          startReq = !st_q.startBlk[c];
          once = 1'b1;
        end
        tsc_pkg::RC_SAVE: saveReq = 1'b1;
        tsc_pkg::RC_STOP: stopReq = 1'b1;
        tsc_pkg::RC_OFF: offReq = 1'b1;
        tsc_pkg::RC_OFF_ONCE: begin
          offReq = !st_q.offBlk[c];
          once = 1'b1;
        end
        default: once = 1'b0;
      endcase

      // all-off and save runs ignore triggers until they finish
      busy = (st_q.mode[c] == tsc_pkg::MD_OFF) || (st_q.mode[c] == tsc_pkg::MD_SAVE);
      if (tick && st_q.gap[c] != 8'h00) begin
        st_d.gap[c] = st_q.gap[c] - 8'h01;
      end

      if (!busy && offReq) begin
        st_d.mode[c] = tsc_pkg::MD_OFF;
        st_d.idx[c] = 3'h0;
        st_d.dly[c] = 8'h00;
        st_d.startBlk[c] = 1'b0;
        st_d.offBlk[c] = st_q.offBlk[c] | once;
      end else if (!busy && startReq) begin
        st_d.mode[c] = tsc_pkg::MD_RUN;
        st_d.idx[c] = 3'h0;
        st_d.dly[c] = pickByte(st_q.cfg[c][tsc_pkg::REG_DLYLO],
                               st_q.cfg[c][tsc_pkg::REG_DLYHI], 3'h0);
        st_d.offBlk[c] = 1'b0;
        st_d.startBlk[c] = st_q.startBlk[c] | once;
      end else if (!busy && saveReq) begin
        st_d.mode[c] = tsc_pkg::MD_SAVE;
        st_d.idx[c] = 3'h0;
        st_d.dly[c] = 8'h00;
      end else if (stopReq && st_q.mode[c] == tsc_pkg::MD_RUN) begin
        st_d.mode[c] = tsc_pkg::MD_IDLE;
      end else if (st_q.mode[c] != tsc_pkg::MD_IDLE) begin
        act = ocfg[tsc_pkg::OUTCFG_EN_LSB + 32'(st_q.idx[c])];
        advance = 1'b0;
        if (!act) begin
          advance = 1'b1;
        end else if (st_q.dly[c] == 8'h00 && st_q.gap[c] == 8'h00 && !taken) begin
          taken = 1'b1;
          advance = 1'b1;
          v = pickByte(st_q.cfg[c][tsc_pkg::REG_VALLO], st_q.cfg[c][tsc_pkg::REG_VALHI],
                       st_q.idx[c]);
          st_d.txValid = 1'b1;
          st_d.txCtl = 2'(c);
          st_d.txOut = st_q.idx[c];
          st_d.txRead = (st_q.mode[c] == tsc_pkg::MD_SAVE);
          st_d.txOff = (st_q.mode[c] == tsc_pkg::MD_OFF);
          st_d.txSwitch = !ocfg[tsc_pkg::OUTCFG_TYPE_LSB + 32'(st_q.idx[c])];
          if (st_q.mode[c] != tsc_pkg::MD_RUN) begin
            st_d.txData = 8'h00;
          end else if (st_d.txSwitch) begin
            st_d.txData = {7'h00, v != 8'h00};
          end else begin
            st_d.txData = v;
          end
          st_d.gap[c] = st_q.cfg[c][tsc_pkg::REG_GAP][tsc_pkg::GAP_LSB +: 8];
        end else if (tick && st_q.dly[c] != 8'h00) begin
          st_d.dly[c] = st_q.dly[c] - 8'h01;
        end
        if (advance) begin
          nIdx = 3'(st_q.idx[c] + 3'h1);
          if (st_q.idx[c] == 3'h7) begin
            st_d.mode[c] = tsc_pkg::MD_IDLE;
          end else begin
            st_d.idx[c] = nIdx;
            st_d.dly[c] = (st_q.mode[c] == tsc_pkg::MD_RUN) ?
              pickByte(st_q.cfg[c][tsc_pkg::REG_DLYLO], st_q.cfg[c][tsc_pkg::REG_DLYHI], nIdx) :
              8'h00;
          end
        end
      end
    end

    if (!reset_n) begin
      st_d = '0;
      st_d.cfg = {(NC * tsc_pkg::NUM_CFG){tsc_pkg::REG_RST}};
      st_d.hreadyOut = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    st_q <= st_d;
  end

  assign hreadyout = st_q.hreadyOut;
  assign hrdata = st_q.hrdata;
  assign hresp = st_q.hresp;
  assign txValid = st_q.txValid;
  assign txCtl = st_q.txCtl;
  assign txOut = st_q.txOut;
  assign txData = st_q.txData;
  assign txRead = st_q.txRead;
  assign txSwitch = st_q.txSwitch;

  // bus and port checks watch the bus slave and the shared telegram port; sequencer checks run per controller
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_BUS_WAIT: assert property ((hsel && hready && htrans[1] && !st_q.busPend)
    |=> !hreadyout ##1 hreadyout) else $error("bus transfer not one wait state");
  AST_OFF_ZERO: assert property (st_q.txValid && st_q.txOff |-> txData == 8'h00)
    else $error("all-off telegram carries a nonzero value");
  AST_GAP_LOAD: assert property (txValid && !txRead |->
    st_q.gap[txCtl] == st_q.cfg[txCtl][tsc_pkg::REG_GAP][7:0])
    else $error("minimum gap not reloaded on send");
  AST_OUT_ACTIVE: assert property (txValid |->
    st_q.cfg[txCtl][tsc_pkg::REG_OUTCFG][{2'b00, txOut}])
    else $error("telegram sent on an inactive output");

  // one code path, but a scenario may land on any controller, so check all four
  for (genvar g = 0; g < NC; g++) begin : gSeqChk
    AST_OFF_DONE: assert property ($past(st_q.mode[g]) == tsc_pkg::MD_OFF &&
      st_q.mode[g] != tsc_pkg::MD_OFF |-> $past(st_q.idx[g]) == 3'h7)
      else $error("all-off ended before output H");
    AST_STOP: assert property (hit[g] && rEff[g] == tsc_pkg::RC_STOP &&
      st_q.mode[g] == tsc_pkg::MD_RUN |=> st_q.mode[g] == tsc_pkg::MD_IDLE)
      else $error("stop did not halt the sequence");
    AST_RETRIG: assert property (hit[g] && rEff[g] == tsc_pkg::RC_RETRIG &&
      st_q.mode[g] == tsc_pkg::MD_RUN |=>
      st_q.mode[g] == tsc_pkg::MD_RUN && st_q.idx[g] == 3'h0)
      else $error("retrigger did not restart at output A");
    AST_DISABLED: assert property (hit[g] && rEff[g] == tsc_pkg::RC_DISABLED &&
      st_q.mode[g] == tsc_pkg::MD_IDLE |=> st_q.mode[g] == tsc_pkg::MD_IDLE)
      else $error("disabled reaction changed the controller");
    AST_START_ONCE: assert property (hit[g] && rEff[g] == tsc_pkg::RC_START_ONCE &&
      st_q.startBlk[g] && st_q.mode[g] == tsc_pkg::MD_IDLE |=>
      st_q.mode[g] == tsc_pkg::MD_IDLE)
      else $error("blocked start-once still started");
  end

endmodule

// ---- tsc_bus_model.sv ----
// far side of the telegram bus: answers read requests after lat cycles
module tsc_bus_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic txValid,
  input wire logic [1:0] txCtl,
  input wire logic [2:0] txOut,
  input wire logic txRead,
  input wire logic [3:0] lat,
  output logic rspValid,
  output logic [1:0] rspCtl,
  output logic [2:0] rspOut,
  output logic [7:0] rspData
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] pq[$];
  int dq[$];
  int cyc = 0;

  // known levels at time zero, before the first edge
  initial begin
    rspValid = 1'b0;
    rspCtl = 2'h0;
    rspOut = 3'h0;
    rspData = 8'h5A;
  end

  // one answer per cycle at most; the data line drifts while idle so stale bytes never match
  always @(posedge clk) begin
    cyc++;
    if (!reset_n) begin
      pq.delete();
      dq.delete();
      rspValid <= 1'b0;
    end else begin
      if (txValid === 1'b1 && txRead === 1'b1) begin
        pq.push_back({txCtl, txOut});
        dq.push_back(cyc + int'(lat));
      end
      if (dq.size() > 0 && dq[0] <= cyc) begin
        rspValid <= 1'b1;
        {rspCtl, rspOut} <= pq[0];
        rspData <= {pq[0], 3'h3};
        pq.pop_front();
        dq.pop_front();
      end else begin
        rspValid <= 1'b0;
        rspData <= ~rspData;
      end
    end
  end
endmodule

// ---- tb_top.sv ----
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value t=%0t got %0h exp %0h", $time, (g), (e)); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 4;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [2:0] hsz = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, txValid, txRead, txSwitch, rspValid;
  logic [31:0] hrdata, rd;
  logic binValid = 1'b0, binValue = 1'b0, scnValid = 1'b0;
  logic [1:0] binCtl = 2'h0, scnCtl = 2'h0, txCtl, rspCtl;
  logic [2:0] txOut, rspOut;
  logic [7:0] scnByte = 8'h0, txData, rspData, en, typ;
  logic [3:0] lat = 4'h1;
  logic [63:0] val;
  logic [14:0] txq[$], exq[$];
  int seed = 6;
  int n_mismatch = 0;
  int checks = 0;
  int c, t0, sn;

  tsc_top #(.TICK_CYCLES(TK)) dut (.clk(clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .binValid(binValid), .binCtl(binCtl), .binValue(binValue), .scnValid(scnValid),
    .scnCtl(scnCtl), .scnByte(scnByte), .rspValid(rspValid), .rspCtl(rspCtl),
    .rspOut(rspOut), .rspData(rspData), .txValid(txValid), .txCtl(txCtl), .txOut(txOut),
    .txData(txData), .txRead(txRead), .txSwitch(txSwitch));

  tsc_bus_model peer (.clk(clk), .reset_n(reset_n), .txValid(txValid), .txCtl(txCtl),
    .txOut(txOut), .txRead(txRead), .lat(lat), .rspValid(rspValid), .rspCtl(rspCtl),
    .rspOut(rspOut), .rspData(rspData));

  initial forever #5 clk = ~clk;

  // every telegram seen on the port, in order
  always @(posedge clk)
    if (txValid === 1'b1) txq.push_back({txCtl, txOut, txData, txRead, txSwitch});

  function automatic logic [31:0] ad(logic [2:0] r);
    return 32'(c) * 32'h20 + {27'h0, r, 2'h0};
  endfunction

  function automatic logic [31:0] cb(logic [2:0] r1, logic [2:0] r0);
    return {21'h0, r0, 1'b0, r1, 4'h1};
  endfunction

  // switch outputs carry on/off only; m 1 = all-off, 2 = read request
  function automatic logic [7:0] ev(int i, int m);
    if (m != 0) return 8'h0;
    return typ[i] ? val[8*i+:8] : {7'h0, |val[8*i+:8]};
  endfunction

  task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
    int n;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= hsz;
    n = 0;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) n_mismatch++;
    htrans <= 2'h0;
    hwdata <= d;
    n = 0;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) n_mismatch++;
    rd = hrdata;
  endtask

  task automatic cfg(logic [31:0] ctl, logic [7:0] dly, logic [7:0] gp);
    en = 8'($random(seed)) | 8'h01;
    typ = 8'($random(seed));
    val = {32'($random(seed)), 32'($random(seed))};
    bus(1'b1, ad(tsc_pkg::REG_OUTCFG), {16'h0, typ, en});
    bus(1'b1, ad(tsc_pkg::REG_GAP), {24'h0, gp});
    bus(1'b1, ad(tsc_pkg::REG_DLYLO), {4{dly}});
    bus(1'b1, ad(tsc_pkg::REG_DLYHI), {4{dly}});
    bus(1'b1, ad(tsc_pkg::REG_VALLO), val[31:0]);
    bus(1'b1, ad(tsc_pkg::REG_VALHI), val[63:32]);
    bus(1'b1, ad(tsc_pkg::REG_CTRL), ctl);
  endtask

  task automatic trig(logic s, logic [7:0] v);
    if (s) begin
      scnValid <= 1'b1;
      scnCtl <= 2'(c);
      scnByte <= v;
    end else begin
      binValid <= 1'b1;
      binCtl <= 2'(c);
      binValue <= v[0];
    end
    @(posedge clk);
    binValid <= 1'b0;
    scnValid <= 1'b0;
    @(posedge clk);
  endtask

  // poll the mode field until the controller is idle
  task automatic widle;
    int n;
    n = 0;
    do begin bus(1'b0, ad(tsc_pkg::REG_STAT), 32'h0); n++; end
    while (rd[1:0] !== 2'h0 && n < 400);
    if (rd[1:0] !== 2'h0) n_mismatch++;
  endtask

  task automatic wq(int k);
    int n;
    n = 0;
    while (txq.size() < k && n < 500) begin @(posedge clk); n++; end
    if (txq.size() < k) n_mismatch++;
  endtask

  task automatic mk(int m);
    for (int i = 0; i < 8; i++)
      if (en[i]) exq.push_back({2'(c), 3'(i), ev(i, m), m == 2, !typ[i]});
  endtask

  task automatic cmpq;
    `CHK(32'(txq.size()), 32'(exq.size()))
    foreach (exq[i]) if (i < txq.size()) `CHK(txq[i], exq[i])
    txq.delete();
    exq.delete();
  endtask

  task automatic summarize;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // a hang costs a mismatch; the whole run needs a few thousand cycles
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    summarize();
  end

  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    c = 3;
    bus(1'b0, ad(tsc_pkg::REG_CTRL), 32'h0);
    `CHK(rd, tsc_pkg::REG_RST)
    c = 2;
    t0 = $random(seed);
    bus(1'b1, ad(tsc_pkg::REG_VALLO), 32'(t0));
    // a byte-sized write and a write to the status word must both be dropped
    hsz = 3'h0;
    bus(1'b1, ad(tsc_pkg::REG_VALLO), ~32'(t0));
    hsz = tsc_pkg::HSIZE_WORD;
    bus(1'b0, ad(tsc_pkg::REG_VALLO), 32'h0);
    `CHK(rd, 32'(t0))
    bus(1'b1, ad(tsc_pkg::REG_STAT), 32'hFFFFFFFF);
    bus(1'b0, ad(tsc_pkg::REG_STAT), 32'h0);
    `CHK(rd, 32'h0)
    bus(1'b1, tsc_pkg::MAP_LIMIT, 32'hFFFFFFFF);
    bus(1'b0, tsc_pkg::MAP_LIMIT, 32'h0);
    `CHK(rd, 32'h0)
    bus(1'b0, 32'h0, 32'h0);
    `CHK(rd, tsc_pkg::REG_RST)
    `CHK(hresp, tsc_pkg::HRESP_OKAY)
    $display("test regs done");
    // each controller: zero is disabled, a second start while running is dropped
    for (c = 0; c < 4; c++) begin
      cfg(cb(tsc_pkg::RC_START, tsc_pkg::RC_DISABLED), 8'h0, 8'($random(seed) & 1));
      trig(1'b0, 8'h0);
      trig(1'b0, 8'h1);
      trig(1'b0, 8'h1);
      widle();
      mk(0);
      cmpq();
    end
    $display("test start done");
    c = $random(seed) & 3;
    cfg(cb(tsc_pkg::RC_RETRIG, tsc_pkg::RC_STOP), 8'h3, 8'($random(seed) & 1));
    trig(1'b0, 8'h1);
    wq(1);
    trig(1'b0, 8'h1);
    widle();
    mk(0);
    exq = {exq[0]};
    mk(0);
    cmpq();
    trig(1'b0, 8'h1);
    wq(1);
    trig(1'b0, 8'h0);
    repeat (100) @(posedge clk);
    `CHK(32'(txq.size()), 32'h1)
    bus(1'b0, ad(tsc_pkg::REG_STAT), 32'h0);
    `CHK(rd[1:0], 2'h0)
    txq.delete();
    $display("test retrigger done");
    // long delays make a delayed all-off visible in its duration
    cfg(cb(tsc_pkg::RC_START_ONCE, tsc_pkg::RC_OFF), 8'hA, 8'h0);
    trig(1'b0, 8'h1);
    widle();
    mk(0);
    cmpq();
    trig(1'b0, 8'h1);
    repeat (60) @(posedge clk);
    `CHK(32'(txq.size()), 32'h0)
    t0 = int'($time);
    trig(1'b0, 8'h0);
    trig(1'b0, 8'h1);
    widle();
    `CHK((int'($time) - t0) / 10 < 30, 1'b1)
    mk(1);
    cmpq();
    trig(1'b0, 8'h1);
    widle();
    mk(0);
    cmpq();
    $display("test once done");
    cfg(cb(tsc_pkg::RC_DISABLED, tsc_pkg::RC_OFF_ONCE), 8'h0, 8'h0);
    trig(1'b0, 8'h1);
    trig(1'b0, 8'h0);
    widle();
    trig(1'b0, 8'h0);
    repeat (40) @(posedge clk);
    mk(1);
    cmpq();
    $display("test off once done");
    // slow answers first, then a start must carry the answered bytes
    lat <= 4'h9;
    cfg(cb(tsc_pkg::RC_SAVE, tsc_pkg::RC_START), 8'h1, 8'h1);
    trig(1'b0, 8'h1);
    widle();
    repeat (30) @(posedge clk);
    mk(2);
    cmpq();
    for (int i = 0; i < 8; i++) if (en[i]) val[8*i+:8] = {2'(c), 3'(i), 3'h3};
    trig(1'b0, 8'h0);
    widle();
    mk(0);
    cmpq();
    $display("test save done");
    lat <= 4'h1;
    sn = $random(seed) & 63;
    cfg({2'h0, 6'(sn), 3'h0, 1'b1, 2'h0, 2'h2, 3'h0, 1'b1, 12'h0}, 8'h3, 8'h0);
    trig(1'b1, 8'(sn ^ 1));
    trig(1'b1, 8'(sn));
    wq(1);
    trig(1'b1, 8'(sn));
    repeat (100) @(posedge clk);
    mk(0);
    exq = {exq[0]};
    cmpq();
    trig(1'b1, 8'(sn) | 8'h80);
    widle();
    repeat (30) @(posedge clk);
    mk(2);
    cmpq();
    // scene start drops a repeat, start once blocks a later match, retrigger restarts
    cfg({2'h0, 6'(sn), 6'h0, 2'h0, 3'h0, 1'b1, 12'h0}, 8'h0, 8'h0);
    trig(1'b1, 8'(sn));
    trig(1'b1, 8'(sn));
    widle();
    mk(0);
    cmpq();
    cfg({2'h0, 6'(sn), 6'h0, 2'h3, 3'h0, 1'b1, 12'h0}, 8'h0, 8'h0);
    trig(1'b1, 8'(sn));
    widle();
    trig(1'b1, 8'(sn));
    repeat (40) @(posedge clk);
    mk(0);
    cmpq();
    cfg({2'h0, 6'(sn), 6'h0, 2'h1, 3'h0, 1'b1, 12'h0}, 8'h3, 8'h0);
    trig(1'b1, 8'(sn));
    wq(1);
    trig(1'b1, 8'(sn));
    widle();
    mk(0);
    exq = {exq[0]};
    mk(0);
    cmpq();
    $display("test scene done");
    summarize();
  end
endmodule
